// *** pkg/alarm_defines.svh ***
/*
  Offsets, field positions, masks and reset values of the calendar alarm
  block. Assumes it is included by its bare name wherever these are used.
*/
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH

// Register offsets on the byte-wide register port.
`define ALM_SECOND_OFS 8'h0A
`define ALM_MINUTE_OFS 8'h0B
`define ALM_HOUR_OFS 8'h0C
`define ALM_MONTHDAY_OFS 8'h0D
`define ALM_DAYOFWEEK_OFS 8'h0E

// Active-low enable bit, common to every alarm register.
`define ALM_DISABLE_BIT 7
`define ALM_DISABLE_RESET 1'b1

// Implemented value bits of each register; all other bits except the disable bit read as zero.
`define ALM_SECOND_MASK 8'h7F
`define ALM_MINUTE_MASK 8'h7F
`define ALM_HOUR_MASK 8'h3F
`define ALM_MONTHDAY_MASK 8'h3F
`define ALM_DAYOFWEEK_MASK 8'h07

// Hour field layout.
`define HOUR_PM_BIT 5
`define HOUR_TENS12_BIT 4
`define HOUR_TENS24_MSB 5
`define HOUR_TENS24_LSB 4
`define HOUR_UNITS_MSB 3
`define HOUR_UNITS_LSB 0

// Value read back for reserved bits and loaded into the read data at reset.
`define ALM_READ_ZERO 8'h00

`endif

// *** pkg/alarm_pkg.sv ***
/*
  Types shared by the calendar alarm block and its surroundings.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package alarm_pkg;

  // One access request on the byte-wide register port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Running time in BCD as held by the time counters (weekday binary).
  typedef struct packed {
    logic [7:0] seconds;
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] monthday;
    logic [7:0] dayofweek;
  } rtc_time_t;

  // Active-low enable bits of the five alarm fields.
  typedef struct packed {
    logic seconds_match_disable;
    logic minute_match_disable;
    logic hour_match_disable;
    logic monthday_match_disable;
    logic dayofweek_match_disable;
  } alarm_disable_t;

  // Stored alarm values, implemented bits only.
  typedef struct packed {
    logic [6:0] seconds;
    logic [6:0] minutes;
    logic [5:0] hours;
    logic [5:0] monthday;
    logic [2:0] dayofweek;
  } alarm_value_t;

endpackage

// *** verification/alarm_host.sv ***
/* Host model issuing byte register accesses.
   Assumes it shares ref_clk with the alarm block. */
`timescale 1ns/100ps
module alarm_host (
  input wire logic ref_clk,
  output alarm_pkg::reg_req_t reg_req
);
  import alarm_pkg::*;
  // Idle bus starts all zero, then carries inverted bytes with both strobes low, so a stale request never looks valid.
  initial reg_req = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) reg_req <= '{w, !w, a, d};
    @(posedge ref_clk) reg_req <= '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule // alarm_host

// *** verification/calendar_alarm_matcher_chk.sv ***
/* Port checker for the calendar alarm matcher.
   Assumes it is bound onto calendar_alarm_matcher. */
`timescale 1ns/100ps
module calendar_alarm_matcher_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire alarm_pkg::reg_req_t reg_req,
  input wire logic reg_rvalid,
  input wire logic time_tick,
  input wire logic flag_clear,
  input wire logic alarm_match_flag,
  input wire logic alarm_match_event
);
  import alarm_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic hit;
  // Decode of the five alarm offsets.
  assign hit = reg_req.addr >= 8'h0A && reg_req.addr <= 8'h0E;
  sequence s_rise;
    !alarm_match_flag ##1 alarm_match_flag;
  endsequence
  read_answer_a: assert property (ce && reg_req.rd && hit |=> reg_rvalid)
    else $error("read not answered");
  foreign_read_a: assert property (ce && reg_req.rd && !hit |=> !reg_rvalid)
    else $error("foreign read answered");
  reset_clear_a: assert property (disable iff (1'b0) rst |=> !alarm_match_flag)
    else $error("flag survives reset");
  flag_sticky_a: assert property (alarm_match_flag && !flag_clear |=> alarm_match_flag)
    else $error("flag dropped");
  flag_clear_a: assert property (ce && flag_clear && !time_tick |=> !alarm_match_flag)
    else $error("flag not cleared");
  tick_only_a: assert property (!alarm_match_flag && !time_tick |=> !alarm_match_flag)
    else $error("flag set off tick");
  event_rise_a: assert property (s_rise |-> alarm_match_event)
    else $error("no event on flag rise");
  event_only_a: assert property (alarm_match_event |-> alarm_match_flag)
    else $error("stray event");
  event_tick_a: assert property (alarm_match_event |-> $past(time_tick))
    else $error("event without tick");
endmodule // calendar_alarm_matcher_chk
bind calendar_alarm_matcher calendar_alarm_matcher_chk calendar_alarm_matcher_chk_inst (
  .ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_req(reg_req), .reg_rvalid(reg_rvalid),
  .time_tick(time_tick), .flag_clear(flag_clear), .alarm_match_flag(alarm_match_flag),
  .alarm_match_event(alarm_match_event));

// *** verification/testbench.sv ***
/* Self-checking bench for the calendar alarm matcher.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/100ps
module testbench;
  import alarm_pkg::*;
  logic ref_clk = 0, rst = 1, ce = 1, time_tick = 0, hour_12_mode = 0, flag_clear = 0;
  rtc_time_t cur_time = '0;
  rtc_time_t hit_t = '{8'h00, 8'h30, 8'h23, 8'h15, 8'h03};
  reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic reg_rvalid, alarm_match_flag, alarm_match_event;
  logic [7:0] expq[$], maskq[$], shadow[5], rd_mask;
  logic [7:0] impl[5] = '{8'h7F, 8'h7F, 8'h3F, 8'h3F, 8'h07};
  integer errors = 0, num_checks = 0, seed = 32'h47d3b819, i;
  always #20 ref_clk = ~ref_clk;
  alarm_host alarm_host_inst (.ref_clk(ref_clk), .reg_req(reg_req));
  calendar_alarm_matcher calendar_alarm_matcher_inst (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .time_tick(time_tick),
    .cur_time(cur_time), .hour_12_mode(hour_12_mode), .flag_clear(flag_clear),
    .alarm_match_flag(alarm_match_flag), .alarm_match_event(alarm_match_event));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic exp);
    cmp({7'h00, alarm_match_flag}, {7'h00, exp});
  endtask
  // Each answered read takes the oldest expectation off the queue.
  always @(posedge ref_clk) begin
    if (reg_rvalid === 1'b1) begin
      if (expq.size() == 0) cmp(8'h01, 8'h00);
      else begin
        rd_mask = maskq.pop_front();
        cmp(reg_rdata & rd_mask, expq.pop_front() & rd_mask);
      end
    end
  end
  // Undefined value bits are masked out of a compare where the mask says.
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    expq.push_back(e);
    maskq.push_back(m);
    alarm_host_inst.acc(1'b0, a, 8'h00);
  endtask
  task automatic tick(input rtc_time_t t, input logic f);
    @(posedge ref_clk) cur_time <= t;
    time_tick <= 1'b1;
    @(posedge ref_clk) time_tick <= 1'b0;
    @(negedge ref_clk) cmp_flag(f);
  endtask
  task automatic pulse_clear;
    @(posedge ref_clk) flag_clear <= 1'b1;
    @(posedge ref_clk) flag_clear <= 1'b0;
  endtask
  task automatic do_reset;
    @(posedge ref_clk) rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // A hung run counts as a mismatch.
  initial begin
    #400000;
    errors++;
    conclude;
  end
  // Register map, reset behaviour, then matching over ticks.
  initial begin
    do_reset;
    for (i = 0; i < 5; i++) rd(8'h0A + i[7:0], 8'h80, 8'h80 | ~impl[i]);
    for (i = 0; i < 5; i++) begin
      shadow[i] = 8'($random(seed));
      alarm_host_inst.acc(1'b1, 8'h0A + i[7:0], shadow[i]);
      rd(8'h0A + i[7:0], shadow[i] & (8'h80 | impl[i]));
    end
    alarm_host_inst.acc(1'b1, 8'h0F, 8'h00);
    alarm_host_inst.acc(1'b0, 8'h09, 8'h00);
    do_reset;
    for (i = 0; i < 5; i++) rd(8'h0A + i[7:0], 8'h80 | (shadow[i] & impl[i]));
    for (i = 0; i < 5; i++) alarm_host_inst.acc(1'b1, 8'h0A + i[7:0], hit_t[39 - 8*i -: 8]);
    tick(hit_t ^ 40'h1, 1'b0);
    tick(hit_t, 1'b1);
    tick(hit_t, 1'b1);
    pulse_clear;
    tick(hit_t, 1'b0);
    for (i = 0; i < 5; i++) tick(hit_t ^ (40'h1 << 8*i), 1'b0);
    alarm_host_inst.acc(1'b1, 8'h0A, 8'h80);
    tick(hit_t ^ (40'h1 << 32), 1'b1);
    pulse_clear;
    @(posedge ref_clk) hour_12_mode <= 1'b1;
    alarm_host_inst.acc(1'b1, 8'h0C, 8'h31);
    tick(hit_t ^ (40'h32 << 16), 1'b0);
    tick(hit_t ^ (40'h12 << 16), 1'b1);
    repeat (4) @(posedge ref_clk);
    if (expq.size() != 0) errors++;
    conclude;
  end
endmodule // testbench

// *** verilog/calendar_alarm_matcher.sv ***
/*
  Calendar alarm matcher: five alarm registers on the byte register port,
  comparison against the running time and the sticky alarm flag.
  The seconds, minute, monthday and weekday compares go through one small
  field module, instantiated once per field; the hour compare stays local
  because its digit layout depends on the selected hour format.
  Assumes the time counters, the tick, the hour format bit and the flag
  clear all come from logic on ref_clk, so none of them is synchronised.
  Assumes time_tick is a single-cycle pulse raised in the same cycle in
  which cur_time shows the freshly counted time.
  Assumes the host never relies on alarm values before it has written
  them, since they power up undefined and no reset touches them.
  Assumes the flag clear is a single-cycle pulse; a longer pulse simply
  keeps the flag low except in a cycle that brings a fresh match.
*/
`timescale 1ns/100ps
`include "alarm_defines.svh"

// Register layout, as seen from the byte register port:
//   0Ah seconds:  bit 7 disable, bits 6:4 tens, bits 3:0 units.
//   0Bh minutes:  bit 7 disable, bits 6:4 tens, bits 3:0 units.
//   0Ch hours:    bit 7 disable, bit 6 reads zero, bits 5:0 hour digits.
//                 In 12-hour format bit 5 is the PM select and bit 4 the
//                 tens digit; in 24-hour format bits 5:4 hold the tens.
//   0Dh monthday: bit 7 disable, bit 6 reads zero, bits 5:4 tens, 3:0 units.
//   0Eh weekday:  bit 7 disable, bits 6:3 read zero, bits 2:0 weekday.
// Both hour formats occupy the same six bit positions, so a stored hour
// compares bit for bit against the running hour in either format; the
// format bit only decides how those six bits are grouped into digits.
// The value bits are never checked for legal BCD. A host that writes an
// impossible value, such as 7Fh minutes, simply gets an alarm that the
// running time can never reach, which is harmless.
// Hazard: the alarm fires on a rising match sampled at a tick. If the host
// rewrites an alarm while the time already equals it, the next tick sees a
// fresh match and sets the flag, which is the intended behaviour.

module calendar_alarm_matcher (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire alarm_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic time_tick,
  input wire alarm_pkg::rtc_time_t cur_time,
  input wire logic hour_12_mode,
  input wire logic flag_clear,
  output logic alarm_match_flag,
  output logic alarm_match_event
);
  import alarm_pkg::*;

  alarm_disable_t disable_r;
  alarm_value_t value_r;
  logic match_prev_r;
  logic wr_second;
  logic wr_minute;
  logic wr_hour;
  logic wr_monthday;
  logic wr_dayofweek;
  logic hit;
  logic [7:0] rdata_nxt;
  logic second_ok;
  logic minute_ok;
  logic hour_eq;
  logic hour_ok;
  logic monthday_ok;
  logic dayofweek_ok;
  logic any_enabled;
  logic match_now;
  logic match_rise;

  // Address decode of write strobes; only one register answers per address.
  always_comb begin
    wr_second = 1'b0;
    wr_minute = 1'b0;
    wr_hour = 1'b0;
    wr_monthday = 1'b0;
    wr_dayofweek = 1'b0;
    if (reg_req.wr && reg_req.addr == `ALM_SECOND_OFS) begin
      wr_second = 1'b1;
    end else if (reg_req.wr && reg_req.addr == `ALM_MINUTE_OFS) begin
      wr_minute = 1'b1;
    end else if (reg_req.wr && reg_req.addr == `ALM_HOUR_OFS) begin
      wr_hour = 1'b1;
    end else if (reg_req.wr && reg_req.addr == `ALM_MONTHDAY_OFS) begin
      wr_monthday = 1'b1;
    end else if (reg_req.wr && reg_req.addr == `ALM_DAYOFWEEK_OFS) begin
      wr_dayofweek = 1'b1;
    end
  end

  // Enable bits reset to disabled, so no compare takes part after reset.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      disable_r <= '{default: `ALM_DISABLE_RESET};
    end else if (ce) begin
      if (wr_second) begin
        disable_r.seconds_match_disable <= reg_req.wdata[`ALM_DISABLE_BIT];
      end
      if (wr_minute) begin
        disable_r.minute_match_disable <= reg_req.wdata[`ALM_DISABLE_BIT];
      end
      if (wr_hour) begin
        disable_r.hour_match_disable <= reg_req.wdata[`ALM_DISABLE_BIT];
      end
      if (wr_monthday) begin
        disable_r.monthday_match_disable <= reg_req.wdata[`ALM_DISABLE_BIT];
      end
      if (wr_dayofweek) begin
        disable_r.dayofweek_match_disable <= reg_req.wdata[`ALM_DISABLE_BIT];
      end
    end
  end

  // Alarm values have no reset: they power up undefined and survive resets.
  // Only implemented bits are stored, so unused positions cannot hold ones.
  always_ff @(posedge ref_clk) begin
    if (ce) begin
      if (wr_second) begin
        value_r.seconds <= 7'(reg_req.wdata & `ALM_SECOND_MASK);
      end
      if (wr_minute) begin
        value_r.minutes <= 7'(reg_req.wdata & `ALM_MINUTE_MASK);
      end
      if (wr_hour) begin
        value_r.hours <= 6'(reg_req.wdata & `ALM_HOUR_MASK);
      end
      if (wr_monthday) begin
        value_r.monthday <= 6'(reg_req.wdata & `ALM_MONTHDAY_MASK);
      end
      if (wr_dayofweek) begin
        value_r.dayofweek <= 3'(reg_req.wdata & `ALM_DAYOFWEEK_MASK);
      end
    end
  end

  // Read multiplexer; reserved bits are padded with zeros.
  always_comb begin
    hit = 1'b1;
    rdata_nxt = `ALM_READ_ZERO;
    if (reg_req.addr == `ALM_SECOND_OFS) begin
      rdata_nxt = {disable_r.seconds_match_disable, value_r.seconds};
    end else if (reg_req.addr == `ALM_MINUTE_OFS) begin
      rdata_nxt = {disable_r.minute_match_disable, value_r.minutes};
    end else if (reg_req.addr == `ALM_HOUR_OFS) begin
      rdata_nxt = {disable_r.hour_match_disable, 1'b0, value_r.hours};
    end else if (reg_req.addr == `ALM_MONTHDAY_OFS) begin
      rdata_nxt = {disable_r.monthday_match_disable, 1'b0, value_r.monthday};
    end else if (reg_req.addr == `ALM_DAYOFWEEK_OFS) begin
      rdata_nxt = {disable_r.dayofweek_match_disable, 4'h0, value_r.dayofweek};
    end else begin
      hit = 1'b0;
    end
  end

  // Read data is registered one cycle after the read strobe.
  // Addresses outside the alarm window are left to other blocks.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= `ALM_READ_ZERO;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_req.rd && hit;
      if (reg_req.rd && hit) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  // Seconds field compare; a disabled field always agrees.
  alarm_field_agree #(
    .WIDTH(7)
  ) second_agree_inst (
    .field_disable(disable_r.seconds_match_disable),
    .alarm_value(value_r.seconds),
    .running_value(cur_time.seconds[6:0]),
    .agree(second_ok)
  );

  // Minute field compare; a disabled field always agrees.
  alarm_field_agree #(
    .WIDTH(7)
  ) minute_agree_inst (
    .field_disable(disable_r.minute_match_disable),
    .alarm_value(value_r.minutes),
    .running_value(cur_time.minutes[6:0]),
    .agree(minute_ok)
  );

  // Day-of-month field compare; a disabled field always agrees.
  alarm_field_agree #(
    .WIDTH(6)
  ) monthday_agree_inst (
    .field_disable(disable_r.monthday_match_disable),
    .alarm_value(value_r.monthday),
    .running_value(cur_time.monthday[5:0]),
    .agree(monthday_ok)
  );

  // Weekday field compare; a disabled field always agrees.
  alarm_field_agree #(
    .WIDTH(3)
  ) dayofweek_agree_inst (
    .field_disable(disable_r.dayofweek_match_disable),
    .alarm_value(value_r.dayofweek),
    .running_value(cur_time.dayofweek[2:0]),
    .agree(dayofweek_ok)
  );

  // Hour compare against the running hour.
  always_comb begin
    // The hour field is read in the format the control bit selects.
    if (hour_12_mode) begin
      hour_eq = (value_r.hours[`HOUR_PM_BIT] == cur_time.hours[`HOUR_PM_BIT])
        && (value_r.hours[`HOUR_TENS12_BIT] == cur_time.hours[`HOUR_TENS12_BIT])
        && (value_r.hours[`HOUR_UNITS_MSB:`HOUR_UNITS_LSB]
          == cur_time.hours[`HOUR_UNITS_MSB:`HOUR_UNITS_LSB]);
    end else begin
      hour_eq = (value_r.hours[`HOUR_TENS24_MSB:`HOUR_TENS24_LSB]
          == cur_time.hours[`HOUR_TENS24_MSB:`HOUR_TENS24_LSB])
        && (value_r.hours[`HOUR_UNITS_MSB:`HOUR_UNITS_LSB]
          == cur_time.hours[`HOUR_UNITS_MSB:`HOUR_UNITS_LSB]);
    end
  end

  // A disabled field always agrees; with every field disabled there is no
  // alarm at all, so an all-disabled setup never raises the flag.
  assign hour_ok = disable_r.hour_match_disable || hour_eq;
  assign any_enabled = ~&disable_r;
  assign match_now = any_enabled
    && second_ok
    && minute_ok
    && hour_ok
    && monthday_ok
    && dayofweek_ok;
  assign match_rise = time_tick && match_now && !match_prev_r;

  // Match state sampled once per time update, to spot a fresh match.
  // Between ticks the history holds, so a register write alone never
  // raises the flag; only the next tick can.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      match_prev_r <= 1'b0;
    end else if (ce && time_tick) begin
      match_prev_r <= match_now;
    end
  end

  // Sticky flag: a new match wins over a clear in the same cycle.
  // Letting the set win means an alarm that arrives while software is
  // clearing an older one is never lost.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alarm_match_flag <= 1'b0;
    end else if (ce) begin
      if (match_rise) begin
        alarm_match_flag <= 1'b1;
      end else if (flag_clear) begin
        alarm_match_flag <= 1'b0;
      end
    end
  end

  // One-cycle pulse marking each setting of the flag.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      alarm_match_event <= 1'b0;
    end else if (ce) begin
      alarm_match_event <= match_rise;
    end
  end

endmodule // calendar_alarm_matcher

// Agreement of one alarm field with its running counterpart.
// A disabled field always agrees, so it drops out of the match.
module alarm_field_agree #(
  parameter int WIDTH = 7
) (
  input wire logic field_disable,
  input wire logic [WIDTH-1:0] alarm_value,
  input wire logic [WIDTH-1:0] running_value,
  output logic agree
);
  import alarm_pkg::*;

  // Equality of the stored digits, overridden by the disable bit.
  assign agree = field_disable || (alarm_value == running_value);

endmodule // alarm_field_agree
